// ---- bench/cpu_model.sv ----
/*
 * Processor model: kicks the watchdog, floats the kick line, routes flag.
 * Assumes the supervisor samples on the rising clock edge.
 */
`default_nettype none
module cpu_model
(
	input wire logic clk, // Clock
	input wire logic kick_en, // Keep kicking
	input wire logic kick_drive, // Drive the kick line
	input wire logic route_wdo, // Flag to manual reset
	input wire logic button_n, // Push button
	input wire logic wdo_n, // Flag from block
	output logic kick, // Kick line
	output logic kick_float, // Kick line floating
	output logic mr_n // Manual reset line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic phase_q = 1'b0;
	logic kick_q = 1'b0;
	always @(negedge clk)
	begin
		phase_q <= ~phase_q;
		if (kick_drive && kick_en && phase_q)
			kick_q <= ~kick_q;
	end
	// Released line shows the inverse level
	assign kick = kick_drive ? kick_q : ~kick_q;
	assign kick_float = !kick_drive;
	assign mr_n = route_wdo ? wdo_n : button_n;
endmodule
`default_nettype wire

// ---- bench/supply_supervisor_props.sv ----
/*
 * Checker on the supervisor top ports.
 * Assumes binding to supply_supervisor on one clock.
 */
`default_nettype none
module supply_supervisor_props
	import supervisor_pkg::*;
#(
	parameter cnt_t RST_PULSE_CYCLES = cnt_t'(20),
	parameter cnt_t WD_TIMEOUT_CYCLES = cnt_t'(50)
)
(
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic supply_low_in, // Supply low
	input wire logic manual_reset_n, // Manual reset
	input wire logic watchdog_kick_in, // Kick
	input wire logic kick_tristate_in, // Kick floating
	input wire logic powerfail_sense_in, // Sense
	input wire logic reset_n, // Reset out
	input wire logic watchdog_flag_out_n, // Flag out
	input wire logic powerfail_flag_out_n // Power-fail out
);
	localparam int P = int'(RST_PULSE_CYCLES);
	localparam int T = int'(WD_TIMEOUT_CYCLES);
	int quiet_q;
	int idle_q;
	int up_q;
	logic kick_q;
	// ****************************************
	// Cycles since trigger, kick and reset
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			quiet_q <= 0;
			idle_q <= 0;
			up_q <= 0;
			kick_q <= 1'b0;
		end
		else
		begin
			quiet_q <= (supply_low_in || !manual_reset_n) ? 0 : quiet_q + 1;
			idle_q <= (!reset_n || kick_tristate_in || watchdog_kick_in != kick_q) ? 0 : idle_q + 1;
			up_q <= (up_q < 15) ? up_q + 1 : up_q;
			kick_q <= watchdog_kick_in;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_trig;
		(supply_low_in || !manual_reset_n) [*5];
	endsequence
	sequence s_float;
		(up_q > 7 && !supply_low_in && kick_tristate_in) [*6];
	endsequence
	property p_rst_hold; s_trig |-> !reset_n; endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset high");
	property p_pulse_min; $rose(reset_n) |-> quiet_q >= P + 2; endproperty
	a_pulse_min: assert property (p_pulse_min) else $error("pulse short");
	property p_pulse_max; quiet_q == P + 8 |-> reset_n; endproperty
	a_pulse_max: assert property (p_pulse_max) else $error("pulse long");
	property p_wdo_low; supply_low_in [*5] |-> !watchdog_flag_out_n; endproperty
	a_wdo_low: assert property (p_wdo_low) else $error("flag high");
	property p_wdo_float; s_float |-> watchdog_flag_out_n; endproperty
	a_wdo_float: assert property (p_wdo_float) else $error("flag low");
	property p_pfo; (up_q > 7 && $stable(powerfail_sense_in)) [*4]
		|-> powerfail_flag_out_n == !powerfail_sense_in; endproperty
	a_pfo: assert property (p_pfo) else $error("pfo wrong");
	property p_wd_late; idle_q == T + 8 |-> !watchdog_flag_out_n; endproperty
	a_wd_late: assert property (p_wd_late) else $error("no timeout");
	property p_wd_early; $fell(watchdog_flag_out_n) && !$past(supply_low_in, 2)
		&& !$past(supply_low_in, 3) && !$past(supply_low_in, 4) |-> idle_q >= T - 1; endproperty
	a_wd_early: assert property (p_wd_early) else $error("early timeout");
	property p_wd_hold; $rose(watchdog_flag_out_n) |-> idle_q < 8; endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("flag rose");
endmodule
`default_nettype wire

// ---- bench/supply_supervisor_tb_top.sv ----
/*
 * Testbench for the supply supervisor with a processor model.
 * Assumes shortened pulse and timeout counts.
 */
`default_nettype none
module supply_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import supervisor_pkg::*;
	localparam int P = 20;
	localparam int T = 50;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic supply_low = 1'b1;
	logic pf_sense = 1'b0;
	logic kick_en = 1'b1;
	logic kick_drive = 1'b1;
	logic route = 1'b0;
	logic button_n = 1'b1;
	logic kick;
	logic kick_float;
	logic mr_n;
	logic reset_n;
	logic wdo_n;
	logic pfo_n;
	int err_total = 0;
	int samples_checked = 0;
	cpu_model i_cpu_model (.clk(clk), .kick_en(kick_en), .kick_drive(kick_drive),
		.route_wdo(route), .button_n(button_n), .wdo_n(wdo_n), .kick(kick),
		.kick_float(kick_float), .mr_n(mr_n));
	supply_supervisor #(.RST_PULSE_CYCLES(cnt_t'(P)), .WD_TIMEOUT_CYCLES(cnt_t'(T)))
	i_supply_supervisor (.clk(clk), .sys_rst(sys_rst), .supply_low_in(supply_low),
		.manual_reset_n(mr_n), .watchdog_kick_in(kick), .kick_tristate_in(kick_float),
		.powerfail_sense_in(pf_sense), .reset_n(reset_n), .watchdog_flag_out_n(wdo_n),
		.powerfail_flag_out_n(pfo_n));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic stop_test;
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_power_up;
		cyc(30);
		chk("reset_n", 1'b0, reset_n);
		chk("wdo_n", 1'b0, wdo_n);
		supply_low = 1'b0;
		cyc(5);
		chk("wdo_n", 1'b1, wdo_n);
		cyc(P - 3);
		chk("reset_n", 1'b0, reset_n);
		cyc(6);
		chk("reset_n", 1'b1, reset_n);
	endtask
	task automatic t_manual;
		kick_en = 1'b0;
		button_n = 1'b0;
		cyc(T + 20);
		chk("reset_n", 1'b0, reset_n);
		chk("wdo_n", 1'b1, wdo_n);
		button_n = 1'b1;
		cyc(P + 2);
		chk("reset_n", 1'b0, reset_n);
		cyc(6);
		chk("reset_n", 1'b1, reset_n);
		cyc(T - 10);
		chk("wdo_n", 1'b1, wdo_n);
		cyc(20);
		chk("wdo_n", 1'b0, wdo_n);
		cyc(20);
		chk("wdo_n", 1'b0, wdo_n);
		chk("reset_n", 1'b1, reset_n);
		kick_en = 1'b1;
		cyc(8);
		chk("wdo_n", 1'b1, wdo_n);
	endtask
	task automatic t_dip;
		button_n = 1'b0;
		cyc(5);
		button_n = 1'b1;
		cyc(P / 2);
		supply_low = 1'b1;
		cyc(3);
		supply_low = 1'b0;
		cyc(P / 2 + 2);
		chk("reset_n", 1'b0, reset_n);
		cyc(P / 2 + 6);
		chk("reset_n", 1'b1, reset_n);
	endtask
	task automatic t_float;
		kick_drive = 1'b0;
		cyc(3 * T);
		chk("wdo_n", 1'b1, wdo_n);
		supply_low = 1'b1;
		cyc(5);
		chk("wdo_n", 1'b0, wdo_n);
		supply_low = 1'b0;
		cyc(5);
		chk("wdo_n", 1'b1, wdo_n);
		cyc(P + 8);
		kick_drive = 1'b1;
	endtask
	task automatic t_route;
		route = 1'b1;
		kick_en = 1'b0;
		cyc(T + 12);
		chk("reset_n", 1'b0, reset_n);
		route = 1'b0;
		kick_en = 1'b1;
		cyc(P + 20);
		chk("reset_n", 1'b1, reset_n);
	endtask
	task automatic t_pfail;
		for (int i = 0; i < 4; i++)
		begin
			pf_sense = i[0];
			cyc(5);
			chk("pfo_n", !pf_sense, pfo_n);
		end
	endtask
	initial
	begin
		cyc(6);
		sys_rst = 1'b0;
		t_power_up();
		t_manual();
		t_dip();
		t_float();
		t_route();
		t_pfail();
		stop_test();
	end
	initial
	begin
		cyc(20000);
		err_total++;
		stop_test();
	end
endmodule
bind supply_supervisor supply_supervisor_props #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES),
	.WD_TIMEOUT_CYCLES(WD_TIMEOUT_CYCLES)) i_supply_supervisor_props (.clk, .sys_rst,
	.supply_low_in, .manual_reset_n, .watchdog_kick_in, .kick_tristate_in,
	.powerfail_sense_in, .reset_n, .watchdog_flag_out_n, .powerfail_flag_out_n);
`default_nettype wire

// ---- rtl/supervisor_pkg.sv ----
/*
 * Shared constants and types for the supply supervisor and its watchdog.
 * Assumes a single free-running 40 MHz timebase clock.
 */
`default_nettype none

package supervisor_pkg;

	// ****************************************
	// Timebase
	// ****************************************
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	// ****************************************
	// Timing figures
	// ****************************************
	localparam int unsigned RST_PULSE_MS = 200;
	localparam int unsigned RST_EXTEND_MS = 100;
	localparam int unsigned WD_TIMEOUT_MS = 1600;
	localparam int unsigned WD_MIN_MS = 1000;
	localparam int unsigned KICK_MIN_NS = 50;

	// Longest durations round down, least durations round up
	localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CYC_PER_MS;
	localparam int unsigned RST_EXTEND_CYC = RST_EXTEND_MS * CYC_PER_MS;
	localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned WD_MIN_CYC = WD_MIN_MS * CYC_PER_MS;
	localparam int unsigned KICK_MIN_CYC = (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Counter type
	// ****************************************
	localparam int unsigned CNT_W = 27;
	typedef logic [CNT_W-1:0] cnt_t;
	localparam cnt_t CNT_ZERO = 27'h0000000;
	localparam cnt_t CNT_ONE = 27'h0000001;

	// ****************************************
	// Reset values of outputs and synchronisers
	// ****************************************
	localparam logic RESET_N_INIT = 1'b0;
	localparam logic WDO_N_INIT = 1'b0;
	localparam logic PFO_N_INIT = 1'b1;
	localparam logic LOW_INIT = 1'b1;
	localparam logic MR_N_INIT = 1'b1;
	localparam logic TRI_INIT = 1'b1;
	localparam logic KICK_INIT = 1'b0;
	localparam logic PF_INIT = 1'b0;

endpackage

`default_nettype wire

// ---- rtl/supply_supervisor.sv ----
/*
 * Supply supervisor: reset pulse generator, watchdog flag and power-fail flag.
 * Assumes a free-running 40 MHz clock; all level inputs arrive asynchronously
 * from analog comparators, a switch or another clock domain.
 */
// Function
// - After supply-low clears, hold reset low about 200 ms, then release.
// - Reset stays low as long as supply-low is active.
// - A supply dip during a reset pulse restarts the full 200 ms pulse count.
// - Watchdog flag goes low after 1.6 s without kick toggle.
// - Reset asserted or kick three-stated holds watchdog counter at zero.
// - Counter starts once reset released and kick driven.
// - Kick pulses of 50 ns count as toggles.
// - Supply-low forces watchdog flag low regardless of counter.
// - Floating kick disables counter; flag then shows low-line only.
// - Manual reset low asserts the reset output.
// - Power-fail flag low while sense reports below 1.2 V reference.
// - Each trigger, including manual reset release, yields a 200 ms pulse.
// - Watchdog flag stays low after timeout until counter cleared.
// - Watchdog flag returns high as soon as supply-low clears.
// - Every kick edge clears the watchdog counter.
`default_nettype none

module supply_supervisor
	import supervisor_pkg::*;
#(
	parameter cnt_t RST_PULSE_CYCLES = cnt_t'(supervisor_pkg::RST_PULSE_CYC),
	parameter cnt_t WD_TIMEOUT_CYCLES = cnt_t'(supervisor_pkg::WD_TIMEOUT_CYC)
)
(
	input wire logic clk, // 40 MHz timebase
	input wire logic sys_rst, // Async reset, active high
	input wire logic supply_low_in, // Supply below threshold, high active
	input wire logic manual_reset_n, // Manual reset, low active
	input wire logic watchdog_kick_in, // Kick line level
	input wire logic kick_tristate_in, // Kick line detected floating
	input wire logic powerfail_sense_in, // Sense below reference, high active
	output logic reset_n, // System reset, low active
	output logic watchdog_flag_out_n, // Timeout or low-line, low active
	output logic powerfail_flag_out_n // Power-fail warning, low active
);

	// ****************************************
	// Parameter checks
	// ****************************************
	generate
		if (RST_PULSE_CYCLES < CNT_ONE)
		begin : g_bad_rst
			$error("reset pulse count must be at least one");
		end
		if (WD_TIMEOUT_CYCLES < CNT_ONE)
		begin : g_bad_wd
			$error("watchdog timeout count must be at least one");
		end
		if (KICK_MIN_CYC < 1)
		begin : g_bad_kick
			$error("kick pulse must span a clock period");
		end
	endgenerate

	// ****************************************
	// State
	// ****************************************
	typedef struct packed
	{
		logic low_meta;
		logic low_sync;
		logic mr_meta;
		logic mr_sync;
		logic tri_meta;
		logic tri_sync;
		logic kick_meta;
		logic kick_sync;
		logic kick_prev;
		logic pf_meta;
		logic pf_sync;
		cnt_t rst_cnt;
		logic reset_n;
		logic wdo_n;
		logic pfo_n;
	} sup_state_t;

	localparam sup_state_t SUP_INIT = '{
		low_meta: LOW_INIT,
		low_sync: LOW_INIT,
		mr_meta: MR_N_INIT,
		mr_sync: MR_N_INIT,
		tri_meta: TRI_INIT,
		tri_sync: TRI_INIT,
		kick_meta: KICK_INIT,
		kick_sync: KICK_INIT,
		kick_prev: KICK_INIT,
		pf_meta: PF_INIT,
		pf_sync: PF_INIT,
		rst_cnt: CNT_ZERO,
		reset_n: RESET_N_INIT,
		wdo_n: WDO_N_INIT,
		pfo_n: PFO_N_INIT
	};

	sup_state_t q, d;
	logic trigger;

	watchdog_if wd ();

	// ****************************************
	// Watchdog timer
	// ****************************************
	watchdog_timer #(
		.TIMEOUT_CYCLES(WD_TIMEOUT_CYCLES)
	) u_watchdog (
		.clk(clk),
		.sys_rst(sys_rst),
		.wd(wd)
	);

	assign wd.hold_clear = ~q.reset_n | q.tri_sync;
	// any edge on the kick line
	assign wd.kick_edge = q.kick_sync ^ q.kick_prev;

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		d = q;

		d.low_meta = supply_low_in;
		d.low_sync = q.low_meta;
		d.mr_meta = manual_reset_n;
		d.mr_sync = q.mr_meta;
		d.tri_meta = kick_tristate_in;
		d.tri_sync = q.tri_meta;
		// every sample kept, a two-cycle pulse is seen
		d.kick_meta = watchdog_kick_in;
		d.kick_sync = q.kick_meta;
		d.kick_prev = q.kick_sync;
		d.pf_meta = powerfail_sense_in;
		d.pf_sync = q.pf_meta;

		trigger = q.low_sync | ~q.mr_sync;

		if (trigger)
		begin
			d.rst_cnt = RST_PULSE_CYCLES;
			d.reset_n = 1'b0;
		end
		else if (q.rst_cnt != CNT_ZERO)
		begin
			d.rst_cnt = q.rst_cnt - CNT_ONE;
			d.reset_n = 1'b0;
		end
		else
		begin
			d.reset_n = 1'b1;
		end

		// flag high as soon as low clears
		d.wdo_n = ~(q.low_sync | wd.expired);

		d.pfo_n = ~q.pf_sync;
	end

	// ****************************************
	// Registers
	// ****************************************
	// all intervals on this clock
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= SUP_INIT;
		end
		else
		begin
			q <= d;
		end
	end

	assign reset_n = q.reset_n;
	assign watchdog_flag_out_n = q.wdo_n;
	assign powerfail_flag_out_n = q.pfo_n;

endmodule

`default_nettype wire

// ---- rtl/watchdog_if.sv ----
/*
 * Carrier between the supervisor top and its watchdog timer.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface watchdog_if;
	logic hold_clear;
	logic kick_edge;
	logic expired;

	modport ctrl (output hold_clear, output kick_edge, input expired);
	modport timer (input hold_clear, input kick_edge, output expired);
endinterface

`default_nettype wire

// ---- rtl/watchdog_timer.sv ----
/*
 * Watchdog timeout counter: counts clock cycles since the last clear.
 * Assumes kick edges and hold come from synchronised logic on clk.
 */
`default_nettype none

module watchdog_timer
	import supervisor_pkg::*;
#(
	parameter cnt_t TIMEOUT_CYCLES = cnt_t'(supervisor_pkg::WD_TIMEOUT_CYC)
)
(
	input wire logic clk, // Timebase clock
	input wire logic sys_rst, // Async reset, active high
	watchdog_if.timer wd // Hold, kick and expiry
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed
	{
		cnt_t cnt;
		logic expired;
	} wd_state_t;

	localparam wd_state_t WD_INIT = '{cnt: CNT_ZERO, expired: 1'b0};

	wd_state_t q, d;

	// ****************************************
	// Parameter checks
	// ****************************************
	// A zero count would run the counter up to its all-ones maximum before expiring
	generate
		if (TIMEOUT_CYCLES < CNT_ONE)
		begin : g_bad_timeout
			$error("watchdog timeout count must be at least one");
		end
	endgenerate

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		d = q;
		if (wd.hold_clear)
		begin
			d.cnt = CNT_ZERO;
			d.expired = 1'b0;
		end
		else if (wd.kick_edge)
		begin
			d.cnt = CNT_ZERO;
			d.expired = 1'b0;
		end
		else if (!q.expired)
		begin
			if (q.cnt == TIMEOUT_CYCLES - CNT_ONE)
			begin
				d.expired = 1'b1;
			end
			else
			begin
				d.cnt = q.cnt + CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q <= WD_INIT;
		end
		else
		begin
			q <= d;
		end
	end

	assign wd.expired = q.expired;

endmodule

`default_nettype wire
